//--- rtl/rtc_timers.sv
/*
 * Watchdog, 8-bit reloading countdown timer and square-wave generator of a
 * serial real-time clock, all run from the crystal divider chain.
 * Assumes the two-wire engine presents decoded register accesses one cycle
 * wide, a one-cycle crystal edge pulse, and a main-supply-good level.
 */
`timescale 1ns/10ps
`include "rtc_timers_regs.svh"

// Contract
// RULE1: Watchdog timeout equals multiplier times resolution 1/16, 1/4, 1 or 4 s.
// RULE2: Watchdog expired flag sets when the timeout elapses unrestarted.
// RULE3: Any watchdog register write restarts the timeout from its start.
// RULE4: Watchdog expiry asserts the watchdog interrupt request.
// RULE5: Writing low seven bits releases request; all zero disables watchdog.
// RULE6: Flags read clears watchdog expired flag but keeps request asserted.
// RULE7: Power-up clears watchdog register, leaving the watchdog disabled.
// RULE8: Countdown runs to 1, then next tick reloads and sets done flag.
// RULE9: Writing countdown value leaves done flag and interrupt untouched.
// RULE10: Countdown writes set the reload value; reads return live count.
// RULE11: Waveform choice 0 holds interrupt low until done flag cleared.
// RULE12: Waveform choice 1 gives one low cycle per n-cycle period.
// RULE13: Free-running mode still sets done flag; clearing it leaves output.
// RULE14: Reload one at 4096 or 64 Hz gives a half-period low pulse.
// RULE15: Reload value zero halts the countdown.
// RULE16: Flags read clears countdown done flag, releasing timer interrupt.
// RULE17: Clearing irq enable releases output; re-enabling with flag reasserts.
// RULE18: Run enable starts/stops, clears on power-down, resumes held count.
// RULE19: Tick source: 4096 Hz, 64 Hz, 1 Hz or 1/60 Hz.
// RULE20: Rate code 0 off, 1 is 32.768 kHz, each step halves to 1 Hz; code 2 gives 8.192 kHz instead of 16.384 kHz.
// RULE21: Square-wave enable gates the selected wave onto the pin.
// RULE22: Main supply below switchover disables the square-wave output.
module rtc_timers (
	input  wire logic                      clk_i,
	input  wire logic                      srst_i,
	input  wire rtc_timers_pkg::reg_req_t  reg_i,
	input  wire logic                      osc_edge_i,
	input  wire logic                      vcc_ok_i,
	output logic [7:0]                     reg_rdata_o,
	output logic                           watchdog_irq_o,
	output logic                           countdown_irq_o,
	output logic                           square_wave_pin_o
);

	rtc_timers_pkg::state_t s_q;
	rtc_timers_pkg::state_t s_d;

	// ------------------------------------------------------------------------
	// Decodes and divider taps
	// ------------------------------------------------------------------------
	logic        wr_wd;
	logic        wr_cdv;
	logic        wr_ctrl;
	logic        rd_flags;
	logic        tick_cd;
	logic        sec_tick;
	logic [17:0] wd_limit;
	logic        cd_reload_now;
	logic        cd_wave;

	assign wr_wd    = reg_i.wr && reg_i.addr == `OFS_WATCHDOG;
	assign wr_cdv   = reg_i.wr && reg_i.addr == `OFS_COUNTDOWN_VALUE;
	assign wr_ctrl  = reg_i.wr && reg_i.addr == `OFS_COUNTDOWN_CTRL;
	assign rd_flags = reg_i.rd && reg_i.addr == `OFS_EVENT_FLAGS;
	assign cd_wave  = s_q.cd_ctrl[`BIT_CTRL_WAVE];
	assign sec_tick = osc_edge_i && (s_q.div & `TICK_MASK_1) == `TICK_MASK_1;

	always_comb
	begin
		unique case (s_q.cd_ctrl[1:0]) // [RULE19]
			2'b00:   tick_cd = osc_edge_i && (s_q.div & `TICK_MASK_4096) == `TICK_MASK_4096;
			2'b01:   tick_cd = osc_edge_i && (s_q.div & `TICK_MASK_64) == `TICK_MASK_64;
			2'b10:   tick_cd = sec_tick;
			default: tick_cd = sec_tick && s_q.sec == `SECONDS_PER_MINUTE;
		endcase
		unique case (s_q.wd_reg[1:0]) // [RULE1]
			2'b00:   wd_limit = `WD_RES_16TH;
			2'b01:   wd_limit = `WD_RES_QUARTER;
			2'b10:   wd_limit = `WD_RES_ONE;
			default: wd_limit = `WD_RES_FOUR;
		endcase
	end

	// Halted with a zero reload, stopped by run enable, and stopped off main supply.
	assign cd_reload_now = tick_cd && vcc_ok_i && s_q.cd_ctrl[`BIT_CTRL_RUN]
		&& s_q.cd_reload != 8'h00 && s_q.cd_cnt <= 8'h01; // [RULE8] [RULE15]

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		if (osc_edge_i)
		begin
			s_d.div = s_q.div + 18'h00001;
		end
		if (sec_tick)
		begin
			s_d.sec = (s_q.sec == `SECONDS_PER_MINUTE) ? 6'h00 : s_q.sec + 6'h01;
		end

		// Watchdog: prescaler counts one resolution step, multiplier counts steps.
		if (s_q.wd_run && osc_edge_i && vcc_ok_i)
		begin
			if (s_q.wd_pre == wd_limit)
			begin
				s_d.wd_pre = 18'h00000;
				s_d.wd_cnt = s_q.wd_cnt - 5'h01;
				if (s_q.wd_cnt == 5'h01)
				begin
					s_d.wd_run   = 1'b0;
					s_d.wd_flag  = 1'b1; // [RULE2]
					s_d.o.wd_irq = 1'b1; // [RULE4]
				end
			end
			else
			begin
				s_d.wd_pre = s_q.wd_pre + 18'h00001;
			end
		end
		if (rd_flags && !(s_d.wd_flag && !s_q.wd_flag))
		begin
			s_d.wd_flag = 1'b0; // [RULE6]
		end
		if (wr_wd)
		begin
			s_d.wd_reg   = reg_i.wdata;
			s_d.wd_pre   = 18'h00000; // [RULE3]
			s_d.wd_cnt   = reg_i.wdata[6:2]; // [RULE1]
			s_d.wd_run   = reg_i.wdata[6:2] != 5'h00; // [RULE5]
			s_d.o.wd_irq = 1'b0; // [RULE5]
		end

		// Countdown timer.
		if (tick_cd && vcc_ok_i && s_q.cd_ctrl[`BIT_CTRL_RUN] && s_q.cd_reload != 8'h00)
		begin
			if (cd_reload_now)
			begin
				s_d.cd_cnt  = s_q.cd_reload; // [RULE8]
				s_d.cd_flag = 1'b1; // [RULE13]
			end
			else
			begin
				s_d.cd_cnt = s_q.cd_cnt - 8'h01; // [RULE18]
			end
		end
		if (rd_flags && !cd_reload_now)
		begin
			s_d.cd_flag = 1'b0; // [RULE16]
		end
		if (wr_cdv)
		begin
			s_d.cd_reload = reg_i.wdata; // [RULE9] [RULE10]
		end
		if (wr_ctrl)
		begin
			s_d.cd_ctrl = reg_i.wdata & 8'hE3;
		end
		if (!vcc_ok_i)
		begin
			s_d.cd_ctrl[`BIT_CTRL_RUN] = 1'b0; // [RULE18]
		end

		// Free-running low pulse length, counted in crystal edges.
		if (cd_reload_now && cd_wave)
		begin
			unique case (s_q.cd_ctrl[1:0])
				2'b00:   s_d.low_cnt = (s_q.cd_reload == 8'h01) ?
					(`LOW_EDGES_4096 >> 1) : `LOW_EDGES_4096; // [RULE14]
				2'b01:   s_d.low_cnt = (s_q.cd_reload == 8'h01) ?
					(`LOW_EDGES_64 >> 1) : `LOW_EDGES_64; // [RULE14]
				default: s_d.low_cnt = `LOW_EDGES_SLOW;
			endcase
		end
		else if (osc_edge_i && s_q.low_cnt != 11'h000)
		begin
			s_d.low_cnt = s_q.low_cnt - 11'h001; // [RULE12]
		end
		if (!cd_wave)
		begin
			s_d.low_cnt = 11'h000;
		end

		// The request mirrors the next flag, or the next pulse count when free-running, so it appears with it.
		if (s_d.cd_ctrl[`BIT_CTRL_WAVE])
		begin
			s_d.o.cd_irq = s_d.cd_ctrl[`BIT_CTRL_IRQ_EN] && s_d.low_cnt != 11'h000; // [RULE13]
		end
		else
		begin
			s_d.o.cd_irq = s_d.cd_ctrl[`BIT_CTRL_IRQ_EN] && s_d.cd_flag; // [RULE11] [RULE17]
		end

		// Square wave.
		if (reg_i.wr && reg_i.addr == `OFS_SQW_ENABLE)
		begin
			s_d.sqw_en = reg_i.wdata[`BIT_SQW_ENABLE];
		end
		if (reg_i.wr && reg_i.addr == `OFS_SQW_RATE)
		begin
			s_d.sqw_rate = reg_i.wdata[`POS_SQW_RATE_LSB +: 4];
		end
		if (s_q.sqw_en && vcc_ok_i && s_q.sqw_rate != 4'h0) // [RULE21] [RULE22]
		begin
			s_d.o.sqw = (s_q.sqw_rate == 4'h1) ? s_q.div[0] : s_q.div[s_q.sqw_rate]; // [RULE20]
		end
		else
		begin
			s_d.o.sqw = 1'b0;
		end

		// Register read data, valid the cycle after the read strobe.
		s_d.o.rdata = 8'h00;
		if (reg_i.rd)
		begin
			unique case (reg_i.addr)
				`OFS_WATCHDOG:        s_d.o.rdata = s_q.wd_reg;
				`OFS_SQW_ENABLE:      s_d.o.rdata = {1'b0, s_q.sqw_en, 6'h00};
				`OFS_EVENT_FLAGS:     s_d.o.rdata = {s_q.wd_flag, 3'h0, s_q.cd_flag, 3'h0};
				`OFS_COUNTDOWN_VALUE: s_d.o.rdata = s_q.cd_cnt; // [RULE10]
				`OFS_COUNTDOWN_CTRL:  s_d.o.rdata = s_q.cd_ctrl;
				`OFS_SQW_RATE:        s_d.o.rdata = {s_q.sqw_rate, 4'h0};
				default:              s_d.o.rdata = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			s_q          <= '0;
			s_q.wd_reg   <= `RST_WATCHDOG; // [RULE7]
			s_q.cd_cnt   <= `RST_COUNTDOWN;
			s_q.cd_ctrl  <= `RST_COUNTDOWN_CTRL;
			s_q.sqw_en   <= `RST_SQW_ENABLE;
			s_q.sqw_rate <= `RST_SQW_RATE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o       = s_q.o.rdata;
	assign watchdog_irq_o    = s_q.o.wd_irq;
	assign countdown_irq_o   = s_q.o.cd_irq;
	assign square_wave_pin_o = s_q.o.sqw;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_wd_last_step;
		s_q.wd_run && osc_edge_i && vcc_ok_i && s_q.wd_pre == wd_limit
			&& s_q.wd_cnt == 5'h01 && !wr_wd;
	endsequence

	property p_wd_expire;
		s_wd_last_step |=> s_q.wd_flag && watchdog_irq_o && !s_q.wd_run;
	endproperty
	a_wd_expire: assert property (p_wd_expire) else $error("watchdog did not expire"); // [RULE2]

	property p_wd_restart;
		wr_wd |=> s_q.wd_pre == 18'h00000 && s_q.wd_cnt == $past(reg_i.wdata[6:2]);
	endproperty
	a_wd_restart: assert property (p_wd_restart) else $error("watchdog not restarted"); // [RULE3]

	property p_wd_release;
		wr_wd |=> !watchdog_irq_o && (s_q.wd_run == ($past(reg_i.wdata[6:2]) != 5'h00));
	endproperty
	a_wd_release: assert property (p_wd_release) else $error("watchdog release wrong"); // [RULE5]

	property p_flags_read_keeps_irq;
		rd_flags && watchdog_irq_o && !wr_wd |=> watchdog_irq_o && !s_q.wd_flag;
	endproperty
	a_flags_read_keeps_irq: assert property (p_flags_read_keeps_irq) else $error("flag read wrong"); // [RULE6]

	property p_reload;
		cd_reload_now |=> s_q.cd_flag && s_q.cd_cnt == $past(s_q.cd_reload);
	endproperty
	a_reload: assert property (p_reload) else $error("countdown reload wrong"); // [RULE8]

	// In free-running mode the pulse counter moves the output on its own, so only the flag is held.
	property p_write_keeps_flag;
		wr_cdv && !cd_reload_now && !rd_flags && !wr_ctrl |=> $stable(s_q.cd_flag)
			&& (cd_wave || $stable(countdown_irq_o));
	endproperty
	a_write_keeps_flag: assert property (p_write_keeps_flag) else $error("value write moved flag"); // [RULE9]

	property p_normal_irq;
		!cd_wave |-> countdown_irq_o == (s_q.cd_flag && s_q.cd_ctrl[`BIT_CTRL_IRQ_EN]);
	endproperty
	a_normal_irq: assert property (p_normal_irq) else $error("normal interrupt mismatch"); // [RULE17]

	property p_halt_zero;
		s_q.cd_reload == 8'h00 && !wr_cdv |=> $stable(s_q.cd_cnt);
	endproperty
	a_halt_zero: assert property (p_halt_zero) else $error("timer ran with zero"); // [RULE15]

	property p_powerdown;
		!vcc_ok_i |=> !s_q.cd_ctrl[`BIT_CTRL_RUN] && !square_wave_pin_o;
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("power-down not honoured"); // [RULE22]

	property p_flags_clear_cd;
		rd_flags && !cd_reload_now |=> !s_q.cd_flag;
	endproperty
	a_flags_clear_cd: assert property (p_flags_clear_cd) else $error("done flag not cleared"); // [RULE16]

	sequence s_fast_reload;
		cd_reload_now && cd_wave && s_q.cd_ctrl[1:0] == 2'b00;
	endsequence

	property p_wave_low_full;
		s_fast_reload ##0 (s_q.cd_reload != 8'h01) |=> s_q.low_cnt == `LOW_EDGES_4096;
	endproperty
	a_wave_low_full: assert property (p_wave_low_full) else $error("pulse length wrong"); // [RULE12]

	property p_wave_low_half;
		s_fast_reload ##0 (s_q.cd_reload == 8'h01)
			|=> s_q.low_cnt == (`LOW_EDGES_4096 >> 1);
	endproperty
	a_wave_low_half: assert property (p_wave_low_half) else $error("half pulse wrong"); // [RULE14]

	property p_wave_irq;
		cd_wave |-> countdown_irq_o
			== (s_q.cd_ctrl[`BIT_CTRL_IRQ_EN] && s_q.low_cnt != 11'h000);
	endproperty
	a_wave_irq: assert property (p_wave_irq) else $error("wave output wrong"); // [RULE13]

	sequence s_cd_count_tick;
		tick_cd && vcc_ok_i && s_q.cd_ctrl[`BIT_CTRL_RUN] && s_q.cd_reload != 8'h00;
	endsequence

	property p_cd_decrement;
		s_cd_count_tick ##0 (s_q.cd_cnt > 8'h01)
			|=> s_q.cd_cnt == $past(s_q.cd_cnt) - 8'h01;
	endproperty
	a_cd_decrement: assert property (p_cd_decrement) else $error("count step wrong"); // [RULE8]

	property p_cd_hold;
		!s_q.cd_ctrl[`BIT_CTRL_RUN] |=> $stable(s_q.cd_cnt);
	endproperty
	a_cd_hold: assert property (p_cd_hold) else $error("stopped timer moved"); // [RULE18]

	property p_wd_count;
		s_q.wd_run && osc_edge_i && vcc_ok_i && s_q.wd_pre != wd_limit && !wr_wd
			|=> s_q.wd_pre == $past(s_q.wd_pre) + 18'h00001;
	endproperty
	a_wd_count: assert property (p_wd_count) else $error("watchdog step wrong"); // [RULE1]

	property p_wd_idle;
		!s_q.wd_run && !wr_wd |=> !s_q.wd_run && !$rose(watchdog_irq_o);
	endproperty
	a_wd_idle: assert property (p_wd_idle) else $error("idle watchdog fired"); // [RULE5]

	property p_rd_count;
		reg_i.rd && reg_i.addr == `OFS_COUNTDOWN_VALUE
			|=> reg_rdata_o == $past(s_q.cd_cnt);
	endproperty
	a_rd_count: assert property (p_rd_count) else $error("live count read wrong"); // [RULE10]

	property p_rd_flags_data;
		rd_flags |=> reg_rdata_o[`BIT_FLAG_WD_EXPIRED] == $past(s_q.wd_flag)
			&& reg_rdata_o[`BIT_FLAG_CD_DONE] == $past(s_q.cd_flag);
	endproperty
	a_rd_flags_data: assert property (p_rd_flags_data) else $error("flags read wrong"); // [RULE6]

	property p_rdata_idle;
		!reg_i.rd |=> reg_rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle"); // [RULE10]

	property p_sqw_off;
		!s_q.sqw_en || s_q.sqw_rate == 4'h0 |=> !square_wave_pin_o;
	endproperty
	a_sqw_off: assert property (p_sqw_off) else $error("square wave not off"); // [RULE21]

	property p_sqw_fast;
		s_q.sqw_en && vcc_ok_i && s_q.sqw_rate == 4'h1
			|=> square_wave_pin_o == $past(s_q.div[0]);
	endproperty
	a_sqw_fast: assert property (p_sqw_fast) else $error("fast square wave wrong"); // [RULE20]

endmodule // rtc_timers

//--- rtl/rtc_timers_regs.svh
/*
 * Register offsets, field positions, reset values and divider counts of the
 * watchdog, countdown timer and square-wave helpers.
 * Assumes a divider chain that advances once per crystal edge (65536 per second).
 */
`ifndef RTC_TIMERS_REGS_SVH
`define RTC_TIMERS_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_WATCHDOG        8'h09
`define OFS_SQW_ENABLE      8'h0A
`define OFS_EVENT_FLAGS     8'h0F
`define OFS_COUNTDOWN_VALUE 8'h10
`define OFS_COUNTDOWN_CTRL  8'h11
`define OFS_SQW_RATE        8'h13

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_WD_OSC_FAIL_IE  7
`define BIT_FLAG_WD_EXPIRED 7
`define BIT_FLAG_CD_DONE    3
`define BIT_CTRL_RUN        7
`define BIT_CTRL_WAVE       6
`define BIT_CTRL_IRQ_EN     5
`define BIT_SQW_ENABLE      6
`define POS_SQW_RATE_LSB    4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_WATCHDOG        8'h00
`define RST_COUNTDOWN       8'h00
`define RST_COUNTDOWN_CTRL  8'h00
`define RST_SQW_ENABLE      1'b0
`define RST_SQW_RATE        4'h0

// ----------------------------------------------------------------------------
// Divider counts, in crystal edges (two per 32.768 kHz cycle)
// ----------------------------------------------------------------------------
`define EDGES_PER_SECOND    32'd65536
`define WD_RES_16TH         18'd4095
`define WD_RES_QUARTER      18'd16383
`define WD_RES_ONE          18'd65535
`define WD_RES_FOUR         18'd262143
`define TICK_MASK_4096      18'h0000F
`define TICK_MASK_64        18'h003FF
`define TICK_MASK_1         18'h0FFFF
`define SECONDS_PER_MINUTE  6'd59
`define LOW_EDGES_4096      11'd16
`define LOW_EDGES_64        11'd1024
`define LOW_EDGES_SLOW      11'd1024

`endif

//--- rtl/rtc_timers_pkg.sv
/*
 * Types shared by the timing helpers: register port bundle and state record.
 * Assumes the constants header is included by the user of these types.
 */
package rtc_timers_pkg;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        wd_irq;
		logic        cd_irq;
		logic        sqw;
		logic [7:0]  rdata;
	} outs_t;

	typedef struct packed {
		logic [17:0] div;
		logic [5:0]  sec;
		logic [7:0]  wd_reg;
		logic [17:0] wd_pre;
		logic [4:0]  wd_cnt;
		logic        wd_run;
		logic        wd_flag;
		logic [7:0]  cd_reload;
		logic [7:0]  cd_cnt;
		logic [7:0]  cd_ctrl;
		logic        cd_flag;
		logic [10:0] low_cnt;
		logic        sqw_en;
		logic [3:0]  sqw_rate;
		outs_t       o;
	} state_t;

endpackage

//--- verification/host_model.sv
/*
 * Host side of the register port: issues one-cycle write and read strobes.
 * Assumes the timer block samples the strobes on the rising clock edge.
 */
`timescale 1ns/10ps
module host_model (
	input  wire logic                 clk_i,
	input  wire logic [7:0]           rdata_i,
	output rtc_timers_pkg::reg_req_t  req_o
);
	initial req_o = '0;
	// The watchdog is kept alive or released only by writing its register.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{1'b1, 1'b0, a, d};
		@(posedge clk_i);
		req_o.wr <= 1'b0;
		req_o.wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_i);
		req_o.rd <= 1'b0;
		#1;
		d = rdata_i;
	endtask
endmodule // host_model

//--- verification/tb_rtc_watchdog_countdown_sqw.sv
/*
 * Self-checking bench of the watchdog, countdown timer and square wave.
 * Assumes one crystal edge every core cycle, so all time counts are in cycles.
 */
`timescale 1ns/10ps
module tb_rtc_watchdog_countdown_sqw;
	logic                     clk_i;
	logic                     srst_i;
	logic                     osc_edge_i;
	logic                     vcc_ok_i;
	rtc_timers_pkg::reg_req_t req;
	logic [7:0]               rdata;
	logic                     wd_irq;
	logic                     cd_irq;
	logic                     sqw;
	logic [7:0]               v;
	logic [7:0]               w;
	int                       fails;
	int                       cmp_count;
	int                       cycles;
	int                       n;
	int                       k;

	host_model u_host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
	rtc_timers u_dut (.clk_i(clk_i), .srst_i(srst_i), .reg_i(req), .osc_edge_i(osc_edge_i),
		.vcc_ok_i(vcc_ok_i), .reg_rdata_o(rdata), .watchdog_irq_o(wd_irq),
		.countdown_irq_o(cd_irq), .square_wave_pin_o(sqw));

	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// The whole run takes about 45000 cycles, so 60000 means a hang.
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			fails++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		u_host.rd(a, v);
		chk({8'h00, v}, {8'h00, exp});
	endtask
	task automatic step(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask
	task automatic wait_hi(input bit wd, input int lim);
		n = 0;
		while (((wd ? wd_irq : cd_irq) !== 1'b1) && n < lim)
		begin
			step(1);
			n++;
		end
	endtask
	// Skips the pulse in flight, which may belong to the old reload value.
	task automatic measure(input logic [7:0] ld, input int hi, input int per);
		u_host.wr(8'h10, ld);
		wait_hi(0, 3000);
		while (cd_irq === 1'b1) step(1);
		wait_hi(0, 3000);
		n = 0;
		while (cd_irq === 1'b1 && n < 3000)
		begin
			step(1);
			n++;
		end
		chk(16'(n), 16'(hi));
		wait_hi(0, 3000);
		chk(16'(n + hi), 16'(per));
	endtask
	task automatic rises(input int exp);
		logic p;
		n = 0;
		p = sqw;
		repeat (256)
		begin
			step(1);
			if (sqw === 1'b1 && p === 1'b0) n++;
			p = sqw;
		end
		chk(16'(n), 16'(exp));
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	initial
	begin
		srst_i = 1'b1;
		osc_edge_i = 1'b1;
		vcc_ok_i = 1'b1;
		fails = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk_i);
		srst_i <= 1'b0;
		rchk(8'h09, 8'h00);
		rchk(8'h11, 8'h00);
		rchk(8'h20, 8'h00);
		u_host.wr(8'h09, 8'h04);
		step(3000);
		u_host.wr(8'h09, 8'h04);
		step(4000);
		chk(16'(wd_irq), 16'h0000);
		wait_hi(1, 300);
		chk(16'(n), 16'h0060);
		rchk(8'h0F, 8'h80);
		chk(16'(wd_irq), 16'h0001);
		rchk(8'h0F, 8'h00);
		u_host.wr(8'h09, 8'h0C);
		step(1);
		chk(16'(wd_irq), 16'h0000);
		step(12000);
		chk(16'(wd_irq), 16'h0000);
		wait_hi(1, 400);
		chk(16'(n), 16'h011F);
		u_host.wr(8'h09, 8'h00);
		step(5000);
		chk(16'(wd_irq), 16'h0000);
		u_host.wr(8'h09, 8'h05);
		step(16000);
		chk(16'(wd_irq), 16'h0000);
		wait_hi(1, 1000);
		chk(16'(n), 16'h0180);
		rchk(8'h0F, 8'h80);
		u_host.wr(8'h09, 8'h00);
		u_host.wr(8'h10, 8'h03);
		u_host.wr(8'h11, 8'hA0);
		wait_hi(0, 200);
		chk(16'(cd_irq), 16'h0001);
		u_host.wr(8'h10, 8'h05);
		step(1);
		chk(16'(cd_irq), 16'h0001);
		u_host.wr(8'h11, 8'h80);
		step(1);
		chk(16'(cd_irq), 16'h0000);
		u_host.wr(8'h11, 8'hA0);
		step(1);
		chk(16'(cd_irq), 16'h0001);
		rchk(8'h0F, 8'h08);
		chk(16'(cd_irq), 16'h0000);
		u_host.wr(8'h11, 8'h20);
		u_host.rd(8'h10, w);
		step(100);
		rchk(8'h10, w);
		chk(16'(w), 16'h0003);
		u_host.wr(8'h11, 8'hA0);
		wait_hi(0, 200);
		chk(16'(n <= 16 * w + 8), 16'h0001);
		u_host.wr(8'h10, 8'h00);
		step(200);
		u_host.rd(8'h0F, v);
		step(200);
		rchk(8'h0F, 8'h00);
		u_host.wr(8'h11, 8'hE0);
		measure(8'h04, 16, 64);
		rchk(8'h0F, 8'h08);
		measure(8'h01, 8, 16);
		u_host.wr(8'h11, 8'hE1);
		measure(8'h01, 512, 1024);
		@(posedge clk_i) vcc_ok_i <= 1'b0;
		step(2);
		rchk(8'h11, 8'h61);
		@(posedge clk_i) vcc_ok_i <= 1'b1;
		u_host.wr(8'h0A, 8'h40);
		for (k = 0; k < 5; k++)
		begin
			u_host.wr(8'h13, 8'(k << 4));
			step(2);
			rises(k == 0 ? 0 : (k == 1 ? 128 : 256 >> (k + 1)));
		end
		u_host.wr(8'h0A, 8'h00);
		step(2);
		rises(0);
		u_host.wr(8'h0A, 8'h40);
		@(posedge clk_i) vcc_ok_i <= 1'b0;
		step(2);
		rises(0);
		give_verdict();
	end
endmodule // tb_rtc_watchdog_countdown_sqw
